// File: cell_pkg.sv
// shared constants and types for the configurable logic cell
package cell_pkg;
    localparam int DATA_W     = 8;
    localparam int ARRAY_IN   = 12;
    localparam int TERMS      = 8;
    localparam int ARRAY_OUT  = 4;
    localparam int CFG_WORDS  = 8;
    localparam int CFG_W      = 16;
    localparam int CFG_AW     = 3;
    localparam int QUEUE_DEPTH = 4;
    localparam int ROUTE_IO   = 6;
    localparam int CTRL_W     = 8;

    // register addresses on the register port
    localparam logic [3:0] ADDR_ACC0   = 4'h0;
    localparam logic [3:0] ADDR_ACC1   = 4'h1;
    localparam logic [3:0] ADDR_OPR0   = 4'h2;
    localparam logic [3:0] ADDR_OPR1   = 4'h3;
    localparam logic [3:0] ADDR_QUEUE0 = 4'h4;
    localparam logic [3:0] ADDR_QUEUE1 = 4'h5;
    localparam logic [3:0] ADDR_CTRL   = 4'h6;
    localparam logic [3:0] ADDR_STAT   = 4'h7;
    localparam logic [3:0] ADDR_STKY   = 4'h8;
    localparam logic [3:0] ADDR_CFGLO  = 4'h9;
    localparam logic [3:0] ADDR_CFGHI  = 4'hA;
    localparam logic [3:0] ADDR_MASK0  = 4'hB;
    localparam logic [3:0] ADDR_MASK1  = 4'hC;
    localparam logic [3:0] ADDR_OMASK  = 4'hD;
    localparam logic [3:0] ADDR_POLY   = 4'hE;
    localparam logic [3:0] ADDR_MODE   = 4'hF;

    localparam logic [7:0]  ZERO8   = 8'h00;
    localparam logic [7:0]  ONES8   = 8'hFF;
    localparam logic [15:0] ZERO16  = 16'h0000;
    localparam logic [2:0]  MSB_DEF = 3'h7;

    // configuration word fields
    localparam int F_OP   = 0;   // [2:0] alu function
    localparam int F_SRCA = 3;   // [4:3] operand a
    localparam int F_SRCB = 5;   // [6:5] operand b
    localparam int F_SHF  = 7;   // [8:7] shift mode
    localparam int F_DST  = 9;   // [10:9] destination
    localparam int F_QWR  = 11;  // [11] queue write
    localparam int F_QRD  = 12;  // [12] queue read into accumulator
    localparam int F_CIN  = 13;  // [14:13] carry source
    localparam int F_CRC  = 15;  // [15] crc step

    typedef enum logic [2:0] {
        OP_PASS = 3'h0, OP_INC = 3'h1, OP_DEC = 3'h2, OP_ADD = 3'h3,
        OP_SUB  = 3'h4, OP_AND = 3'h5, OP_OR  = 3'h6, OP_XOR = 3'h7
    } alu_op_e;

    typedef enum logic [1:0] {
        SH_NONE = 2'h0, SH_LEFT = 2'h1, SH_RIGHT = 2'h2, SH_SWAP = 2'h3
    } shift_e;

    typedef enum logic [1:0] {
        CIN_ZERO = 2'h0, CIN_CHAIN = 2'h1, CIN_SAVED = 2'h2, CIN_ONE = 2'h3
    } cin_e;
endpackage

// File: queue_if.sv
// valid and ready link between the cell and one byte queue
`timescale 1ns/1ps
interface queue_if;
    import cell_pkg::*;
    logic [DATA_W-1:0] inData;
    logic              inValid;
    logic              inReady;
    logic [DATA_W-1:0] outData;
    logic              outValid;
    logic              outReady;
    modport fill  (output inData, output inValid, input inReady,
                   input outData, input outValid, output outReady);
    modport queue (input inData, input inValid, output inReady,
                   output outData, output outValid, input outReady);
endinterface

// File: byte_queue.sv
// parameterised flip-flop queue with valid and ready on both sides
`timescale 1ns/1ps
module byte_queue #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic ref_clk,
    input  wire logic srst,
    queue_if.queue    q
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    wire              doWr = q.inValid && q.inReady;
    wire              doRd = q.outValid && q.outReady;

    assign q.inReady  = (count_q != (AW+1)'(DEPTH));
    assign q.outValid = (count_q != '0);
    assign q.outData  = mem[rdPtr_q];

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (doWr) begin
                mem[wrPtr_q] <= q.inData;
                wrPtr_q      <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (doRd) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(doWr) - (AW+1)'(doRd);
        end
    end
endmodule

// File: logic_array.sv
// sum-of-products logic array with 12 inputs, 8 shared terms, 4 outputs
`timescale 1ns/1ps
module logic_array
    import cell_pkg::*;
(
    input  wire logic                            ref_clk,
    input  wire logic                            srst,
    input  wire logic [ARRAY_IN-1:0]             arrayIn,
    input  wire logic [TERMS-1:0][ARRAY_IN-1:0]  useTrue,
    input  wire logic [TERMS-1:0][ARRAY_IN-1:0]  useComp,
    input  wire logic [ARRAY_OUT-1:0][TERMS-1:0] sumSel,
    input  wire logic [ARRAY_OUT-1:0]            regSel,
    output logic      [ARRAY_OUT-1:0]            arrayOut
);
    logic [TERMS-1:0]     term;
    logic [ARRAY_OUT-1:0] sum;
    logic [ARRAY_OUT-1:0] sumReg_q;

    genvar t, o;
    generate
        for (t = 0; t < TERMS; t++) begin : g_term
            // each input may join as true, complement, or be left out
            assign term[t] = &((arrayIn | ~useTrue[t]) & (~arrayIn | ~useComp[t]));
        end
        for (o = 0; o < ARRAY_OUT; o++) begin : g_out
            assign sum[o] = |(term & sumSel[o]);
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (srst) sumReg_q <= '0;
        else      sumReg_q <= sum;
    end

    assign arrayOut = (regSel & sumReg_q) | (~regSel & sum);
endmodule

// File: logic_datapath_cell.sv
// configurable logic cell: two logic arrays, 8-bit datapath, queues, status and control
`timescale 1ns/1ps
module logic_datapath_cell
    import cell_pkg::*;
(
    input  wire logic                                  ref_clk,
    input  wire logic                                  srst,
    input  wire logic [3:0]                            regAddr,
    input  wire logic [DATA_W-1:0]                     regWrData,
    input  wire logic                                  regWrEn,
    input  wire logic                                  regRdEn,
    output logic      [DATA_W-1:0]                     regRdData,
    input  wire logic [1:0][ARRAY_IN-1:0]              arrayIn,
    input  wire logic [1:0][TERMS-1:0][ARRAY_IN-1:0]   arrayTrue,
    input  wire logic [1:0][TERMS-1:0][ARRAY_IN-1:0]   arrayComp,
    input  wire logic [1:0][ARRAY_OUT-1:0][TERMS-1:0]  arraySum,
    input  wire logic [1:0][ARRAY_OUT-1:0]             arrayReg,
    output logic      [1:0][ARRAY_OUT-1:0]             arrayOut,
    input  wire logic [ROUTE_IO-1:0]                   routeIn,
    output logic      [ROUTE_IO-1:0]                   routeOut,
    input  wire logic                                  chainCarryIn,
    input  wire logic                                  chainShiftIn,
    input  wire logic                                  chainCondIn,
    output logic                                       chainCarryOut,
    output logic                                       chainShiftOut,
    output logic                                       chainCondOut,
    input  wire logic [CTRL_W-1:0]                     fabricStatus,
    output logic      [CTRL_W-1:0]                     fabricControl
);
    import cell_pkg::*;

    logic [DATA_W-1:0] acc0_q, acc0_d, acc1_q, acc1_d, opr0_q, opr1_q;
    logic [CFG_W-1:0]  cfgRam_q [CFG_WORDS];
    logic [CFG_AW-1:0] cfgIdx_q;
    logic [DATA_W-1:0] mask0_q, mask1_q, outMask_q, poly_q, ctrl_q, sticky_q, stat_q;
    logic [DATA_W-1:0] mode_q, rdData_q, lastRd0_q, lastRd1_q;
    logic              savedCarry_q, savedShift_q;
    logic [ROUTE_IO-1:0] routeOut_q;
    logic [1:0][ARRAY_OUT-1:0] arrayOut_w;
    logic              chainCarry_q, chainShift_q, chainCond_q;

    // mode register: [1:0] queue direction, [4:2] msb, [5] mux phase, [7:6] output select
    wire [1:0] qOutDir  = mode_q[1:0];
    wire [2:0] msbPos   = mode_q[4:2];
    wire       tmuxOn   = mode_q[5];
    wire [1:0] routeSel = mode_q[7:6];

    genvar a;
    generate
        for (a = 0; a < 2; a++) begin : g_array
            logic_array u_array (
                .ref_clk  (ref_clk),
                .srst     (srst),
                .arrayIn  (arrayIn[a]),
                .useTrue  (arrayTrue[a]),
                .useComp  (arrayComp[a]),
                .sumSel   (arraySum[a]),
                .regSel   (arrayReg[a]),
                .arrayOut (arrayOut_w[a])
            );
        end
    endgenerate

    // queues
    queue_if q0 ();
    queue_if q1 ();
    byte_queue #(.WIDTH(DATA_W), .DEPTH(QUEUE_DEPTH)) u_q0 (
        .ref_clk (ref_clk), .srst (srst), .q (q0.queue));
    byte_queue #(.WIDTH(DATA_W), .DEPTH(QUEUE_DEPTH)) u_q1 (
        .ref_clk (ref_clk), .srst (srst), .q (q1.queue));

    // routed configuration select and serial input
    wire [CFG_AW-1:0] cfgAddr  = routeIn[2:0];
    wire              serialIn = routeIn[3];
    wire [CFG_W-1:0]  cfg      = cfgRam_q[cfgIdx_q];
    wire [2:0]        aluOp    = cfg[F_OP+:3];
    wire [1:0]        srcA     = cfg[F_SRCA+:2];
    wire [1:0]        srcB     = cfg[F_SRCB+:2];
    wire [1:0]        shMode   = cfg[F_SHF+:2];
    wire [1:0]        dst      = cfg[F_DST+:2];
    wire              qWr      = cfg[F_QWR];
    wire              qRd      = cfg[F_QRD];
    wire [1:0]        cinSel   = cfg[F_CIN+:2];
    wire              crcStep  = cfg[F_CRC];

    // operand selection: accumulators and operand registers
    wire [DATA_W-1:0] opA = (srcA == 2'h0) ? acc0_q : (srcA == 2'h1) ? acc1_q :
                            (srcA == 2'h2) ? opr0_q : opr1_q;
    wire [DATA_W-1:0] opB = (srcB == 2'h0) ? opr0_q : (srcB == 2'h1) ? opr1_q :
                            (srcB == 2'h2) ? acc0_q : acc1_q;

    // carry in: zero, neighbour, saved or one
    wire carryIn = (cinSel == CIN_CHAIN) ? chainCarryIn :
                   (cinSel == CIN_SAVED) ? savedCarry_q :
                   (cinSel == CIN_ONE)   ? 1'b1 : 1'b0;
    wire shiftIn = tmuxOn ? savedShift_q : (chainShiftIn | serialIn);

    // alu with carry out at the programmed msb
    logic [DATA_W:0] aluWide;
    always_comb begin
        case (alu_op_e'(aluOp))
            OP_INC:  aluWide = {1'b0, opA} + 9'h001;
            OP_DEC:  aluWide = {1'b0, opA} - 9'h001;
            OP_ADD:  aluWide = {1'b0, opA} + {1'b0, opB} + {8'h00, carryIn};
            OP_SUB:  aluWide = {1'b0, opA} - {1'b0, opB} - {8'h00, carryIn};
            OP_AND:  aluWide = {1'b0, opA & opB};
            OP_OR:   aluWide = {1'b0, opA | opB};
            OP_XOR:  aluWide = {1'b0, opA ^ opB};
            default: aluWide = {1'b0, opA};
        endcase
    end
    wire [DATA_W-1:0] aluRes   = aluWide[DATA_W-1:0];
    wire [DATA_W-1:0] msbMask  = ONES8 >> (MSB_DEF - msbPos);
    wire              carryOut = (msbPos == MSB_DEF) ? aluWide[DATA_W] : aluRes[msbPos + 3'h1];
    wire              aluMsb   = aluRes[msbPos];
    // subtract overflows when operand signs differ, add when they agree
    wire              ovf      = (opA[msbPos] == (opB[msbPos] ^ (aluOp == OP_SUB))) &&
                                 (aluMsb != opA[msbPos]) && (aluOp == OP_ADD || aluOp == OP_SUB);

    // crc or pseudo-random step over the programmed width
    wire              fb       = aluMsb ^ shiftIn;
    wire [DATA_W-1:0] crcRes   = (({aluRes[DATA_W-2:0], 1'b0}) ^ (fb ? poly_q : ZERO8)) & msbMask;

    // shift stage and OR mask
    logic [DATA_W-1:0] shRes;
    always_comb begin
        case (shift_e'(shMode))
            SH_LEFT:  shRes = {aluRes[DATA_W-2:0], shiftIn} & msbMask;
            SH_RIGHT: shRes = ((aluRes & msbMask) >> 1) | (shiftIn ? (8'h01 << msbPos) : ZERO8);
            SH_SWAP:  shRes = {aluRes[3:0], aluRes[7:4]};
            default:  shRes = aluRes;
        endcase
    end
    wire [DATA_W-1:0] dpRes    = (crcStep ? crcRes : shRes) | outMask_q;
    wire              shiftOut = (shMode == SH_RIGHT) ? aluRes[0] : aluMsb;

    // compares and conditions
    wire [DATA_W-1:0] cmpA1 = mode_q[5] ? acc1_q : opr1_q;
    wire cmpEq0  = ((acc0_q ^ opr0_q) & mask0_q) == ZERO8;
    wire cmpLt0  = (acc0_q & mask0_q) < (opr0_q & mask0_q);
    wire cmpEq1  = (((srcA[0] ? acc1_q : acc0_q) ^ cmpA1) & mask1_q) == ZERO8;
    wire zeroDet = (acc0_q & msbMask) == ZERO8;
    wire onesDet = (acc0_q & msbMask) == msbMask;
    wire [ROUTE_IO-1:0] condSel =
        (routeSel == 2'h0) ? {shiftOut, cmpLt0, cmpEq1, cmpEq0, zeroDet, ovf} :
        (routeSel == 2'h1) ? {shiftOut, onesDet, ~q1.inReady, q1.outValid,
                              ~q0.inReady, q0.outValid} :
        (routeSel == 2'h2) ? {shiftOut, carryOut, chainCondIn & cmpEq0, onesDet, zeroDet, ovf} :
                             {shiftOut, carryOut, cmpLt0, cmpEq1, cmpEq0, zeroDet};

    // queue links: direction 0 means bus fills, datapath drains
    wire selQ0  = (regAddr == ADDR_QUEUE0);
    wire selQ1  = (regAddr == ADDR_QUEUE1);
    wire dpQ0   = qRd && !qOutDir[0] && q0.outValid;
    wire dpQ1   = qRd && !qOutDir[1] && q1.outValid;
    assign q0.inData   = qOutDir[0] ? (dst[0] ? dpRes : acc0_q) : regWrData;
    assign q0.inValid  = qOutDir[0] ? qWr : (regWrEn && selQ0);
    assign q0.outReady = qOutDir[0] ? (regRdEn && selQ0) : dpQ0;
    assign q1.inData   = qOutDir[1] ? (dst[1] ? dpRes : acc1_q) : regWrData;
    assign q1.inValid  = qOutDir[1] ? qWr : (regWrEn && selQ1);
    assign q1.outReady = qOutDir[1] ? (regRdEn && selQ1) : dpQ1;

    // accumulator next values; operand registers never take alu results
    always_comb begin
        acc0_d = acc0_q;
        acc1_d = acc1_q;
        if (dpQ0)                  acc0_d = q0.outData;
        else if (dst == 2'h1)      acc0_d = dpRes;
        if (dpQ1)                  acc1_d = q1.outData;
        else if (dst == 2'h2)      acc1_d = dpRes;
        if (regWrEn && regAddr == ADDR_ACC0) acc0_d = regWrData;
        if (regWrEn && regAddr == ADDR_ACC1) acc1_d = regWrData;
    end

    // read data selection
    wire [DATA_W-1:0] q0Rd = q0.outValid ? q0.outData : lastRd0_q;
    wire [DATA_W-1:0] q1Rd = q1.outValid ? q1.outData : lastRd1_q;
    wire [DATA_W-1:0] cfgRdWord_lo = cfgRam_q[ctrl_q[2:0]][7:0];
    wire [DATA_W-1:0] cfgRdWord_hi = cfgRam_q[ctrl_q[2:0]][15:8];
    logic [DATA_W-1:0] rdMux;
    always_comb begin
        if (regAddr == ADDR_ACC0)        rdMux = acc0_q;
        else if (regAddr == ADDR_ACC1)   rdMux = acc1_q;
        else if (regAddr == ADDR_OPR0)   rdMux = opr0_q;
        else if (regAddr == ADDR_OPR1)   rdMux = opr1_q;
        else if (regAddr == ADDR_QUEUE0) rdMux = q0Rd;
        else if (regAddr == ADDR_QUEUE1) rdMux = q1Rd;
        else if (regAddr == ADDR_CTRL)   rdMux = ctrl_q;
        else if (regAddr == ADDR_STAT)   rdMux = stat_q;
        else if (regAddr == ADDR_STKY)   rdMux = sticky_q;
        else if (regAddr == ADDR_CFGLO)  rdMux = cfgRdWord_lo;
        else if (regAddr == ADDR_CFGHI)  rdMux = cfgRdWord_hi;
        else if (regAddr == ADDR_MASK0)  rdMux = mask0_q;
        else if (regAddr == ADDR_MASK1)  rdMux = mask1_q;
        else if (regAddr == ADDR_OMASK)  rdMux = outMask_q;
        else if (regAddr == ADDR_POLY)   rdMux = poly_q;
        else                             rdMux = mode_q;
    end

    // sticky bits: bit n latches fabric status n, bit 0 also latches compare match
    wire [DATA_W-1:0] stickySet = fabricStatus | {7'h00, cmpEq0};
    wire              stickyRd  = regRdEn && (regAddr == ADDR_STKY);

    // accumulators, config index, status and sticky bits
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            acc0_q <= ZERO8;
            acc1_q <= ZERO8;
            cfgIdx_q <= '0;
            sticky_q <= ZERO8;
            stat_q <= ZERO8;
        end else begin
            cfgIdx_q <= cfgAddr;
            acc0_q <= acc0_d;
            acc1_q <= acc1_d;
            stat_q <= fabricStatus;
            // set wins over the read clear
            sticky_q <= (stickyRd ? ZERO8 : sticky_q) | stickySet;
        end
    end

    // read data and last byte taken from each outgoing queue
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdData_q <= ZERO8;
            lastRd0_q <= ZERO8;
            lastRd1_q <= ZERO8;
        end else begin
            if (regRdEn) rdData_q <= rdMux;
            if (q0.outReady && q0.outValid && qOutDir[0]) lastRd0_q <= q0.outData;
            if (q1.outReady && q1.outValid && qOutDir[1]) lastRd1_q <= q1.outData;
        end
    end

    // bus-written setup registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            opr0_q <= ZERO8;
            opr1_q <= ZERO8;
            mask0_q <= ONES8;
            mask1_q <= ONES8;
            outMask_q <= ZERO8;
            poly_q <= ZERO8;
            ctrl_q <= ZERO8;
            mode_q <= {3'h0, MSB_DEF, 2'h0};
        end else if (regWrEn) begin
            if (regAddr == ADDR_OPR0)       opr0_q <= regWrData;
            else if (regAddr == ADDR_OPR1)  opr1_q <= regWrData;
            else if (regAddr == ADDR_CTRL)  ctrl_q <= regWrData;
            else if (regAddr == ADDR_MASK0) mask0_q <= regWrData;
            else if (regAddr == ADDR_MASK1) mask1_q <= regWrData;
            else if (regAddr == ADDR_OMASK) outMask_q <= regWrData;
            else if (regAddr == ADDR_POLY)  poly_q <= regWrData;
            else if (regAddr == ADDR_MODE)  mode_q <= regWrData;
        end
    end

    // configuration ram written a byte at a time through the index in control bits 2:0
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < CFG_WORDS; i++) cfgRam_q[i] <= ZERO16;
        end else if (regWrEn && regAddr == ADDR_CFGLO) begin
            cfgRam_q[ctrl_q[2:0]][7:0] <= regWrData;
        end else if (regWrEn && regAddr == ADDR_CFGHI) begin
            cfgRam_q[ctrl_q[2:0]][15:8] <= regWrData;
        end
    end

    // saved carry and shift, chain and routed outputs
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            savedCarry_q <= 1'b0;
            savedShift_q <= 1'b0;
            chainCarry_q <= 1'b0;
            chainShift_q <= 1'b0;
            chainCond_q <= 1'b0;
            routeOut_q <= '0;
            arrayOut <= '0;
        end else begin
            savedCarry_q <= carryOut;
            savedShift_q <= shiftOut;
            chainCarry_q <= carryOut;
            chainShift_q <= shiftOut;
            chainCond_q <= cmpEq0 & chainCondIn;
            routeOut_q <= condSel;
            arrayOut <= arrayOut_w;
        end
    end

    assign regRdData     = rdData_q;
    assign routeOut      = routeOut_q;
    assign chainCarryOut = chainCarry_q;
    assign chainShiftOut = chainShift_q;
    assign chainCondOut  = chainCond_q;
    assign fabricControl = ctrl_q;
endmodule

// File: cell_monitor.sv
// register port and control checks for the logic cell
`timescale 1ns/1ps
module cell_monitor (
    input wire logic                          ref_clk,
    input wire logic                          srst,
    input wire logic [3:0]                    regAddr,
    input wire logic [cell_pkg::DATA_W-1:0]   regWrData,
    input wire logic                          regWrEn,
    input wire logic                          regRdEn,
    input wire logic [cell_pkg::DATA_W-1:0]   regRdData,
    input wire logic [cell_pkg::CTRL_W-1:0]   fabricStatus,
    input wire logic [cell_pkg::CTRL_W-1:0]   fabricControl
);
    import cell_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire logic ctlWr = regWrEn && regAddr == ADDR_CTRL;
    a_ctrl_write: assert property (ctlWr |=> fabricControl == $past(regWrData))
        else $error("control write not driven out");
    a_ctrl_hold: assert property (!ctlWr |=> $stable(fabricControl))
        else $error("control changed without write");
    a_ctrl_persist: assert property (ctlWr ##1 !ctlWr [*3] |-> fabricControl == $past(regWrData, 3))
        else $error("control value not kept");
    a_status_read: assert property (regRdEn && regAddr == ADDR_STAT |=> regRdData == $past(fabricStatus, 2))
        else $error("status read differs from fabric");
    a_read_hold: assert property (!regRdEn |=> $stable(regRdData))
        else $error("read data changed without read");
    a_opr_readback: assert property (regWrEn && regAddr == ADDR_OPR0 ##1 regRdEn && !regWrEn && regAddr == ADDR_OPR0 |=> regRdData == $past(regWrData, 2))
        else $error("operand register readback wrong");
    a_ctrl_readback: assert property (regRdEn && !regWrEn && regAddr == ADDR_CTRL |=> regRdData == $past(fabricControl))
        else $error("control readback wrong");
    a_reset_clear: assert property ($fell(srst) |-> fabricControl == ZERO8 && regRdData == ZERO8)
        else $error("outputs not cleared by reset");
endmodule

// File: fabric_model.sv
// routing fabric stand-in: config select and status levels
`timescale 1ns/1ps
module fabric_model (
    input  wire logic                          ref_clk,
    input  wire logic [cell_pkg::CFG_AW-1:0]   cfgSel,
    input  wire logic [cell_pkg::CTRL_W-1:0]   fabricControl,
    output logic      [cell_pkg::ROUTE_IO-1:0] routeIn,
    output logic      [cell_pkg::CTRL_W-1:0]   fabricStatus
);
    import cell_pkg::*;
    always_ff @(posedge ref_clk) begin
        routeIn <= {3'h0, cfgSel};
        fabricStatus <= {fabricControl[3:0], ~fabricControl[7:4]};
    end
endmodule

// File: logic_datapath_cell_bench.sv
// self-checking bench for the logic datapath cell
`timescale 1ns/1ps
module logic_datapath_cell_bench;
    import cell_pkg::*;
    logic                                  ref_clk, srst, regWrEn, regRdEn;
    logic [3:0]                            regAddr;
    logic [7:0]                            regWrData, regRdData, fabricStatus, fabricControl, v;
    logic [1:0][ARRAY_IN-1:0]              arrayIn;
    logic [1:0][TERMS-1:0][ARRAY_IN-1:0]   arrayTrue, arrayComp;
    logic [1:0][ARRAY_OUT-1:0][TERMS-1:0]  arraySum;
    logic [1:0][ARRAY_OUT-1:0]             arrayReg, arrayOut;
    logic [5:0]                            routeIn, routeOut;
    logic [2:0]                            cfgSel;
    logic                                  cIn;
    int                                    n_errors = 0, samples_checked = 0;
    logic [3:0] rowAddr [5] = '{ADDR_OPR0, ADDR_OPR1, ADDR_ACC0, ADDR_ACC1, ADDR_CTRL};
    logic [7:0] rowData [5] = '{8'hA5, 8'h3C, 8'h81, 8'h7E, 8'h96};
    logic [7:0] rowExp  [5] = '{8'hA5, 8'h3C, 8'h81, 8'h7E, 8'h96};
    logic_datapath_cell DUT (.ref_clk(ref_clk), .srst(srst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .arrayIn(arrayIn), .arrayTrue(arrayTrue), .arrayComp(arrayComp), .arraySum(arraySum),
        .arrayReg(arrayReg), .arrayOut(arrayOut), .routeIn(routeIn), .routeOut(routeOut),
        .chainCarryIn(cIn), .chainShiftIn(1'b0), .chainCondIn(1'b0), .chainCarryOut(),
        .chainShiftOut(), .chainCondOut(), .fabricStatus(fabricStatus),
        .fabricControl(fabricControl));
    fabric_model FAB (.ref_clk(ref_clk), .cfgSel(cfgSel), .fabricControl(fabricControl),
        .routeIn(routeIn), .fabricStatus(fabricStatus));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task idle(input int n);
        {regWrEn, regRdEn} = 2'b00;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        regRdEn = 1'b0;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge ref_clk);
        #1;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d);
        regWrEn = 1'b0;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge ref_clk);
        #1;
        d = regRdData;
    endtask
    task close_out;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge ref_clk);
        n_errors++;
        close_out;
    end
    initial begin
        {regAddr, regWrData, cfgSel, cIn} = '0;
        {arrayIn, arrayTrue, arrayComp, arraySum, arrayReg} = '0;
        srst = 1'b1;
        idle(12);
        srst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            wr(rowAddr[i], rowData[i]);
            rd(rowAddr[i], v);
            chk("register row", v, rowExp[i]);
        end
        chk("control out", fabricControl, 8'h96);
        idle(1);
        rd(ADDR_STAT, v);
        chk("status", v, 8'h66);
        wr(ADDR_STAT, 8'h00);
        rd(ADDR_STAT, v);
        chk("status read-only", v, 8'h66);
        $display("done: registers");
        wr(ADDR_MODE, 8'h40);
        for (int i = 1; i < 6; i++) wr(ADDR_QUEUE0, 8'(i * 17));
        idle(2);
        chk("queue full flags", 8'(routeOut[1:0]), 8'h03);
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_CFGLO, 8'h00);
        wr(ADDR_CFGHI, 8'h12);
        cfgSel = 3'h1;
        idle(8);
        cfgSel = 3'h0;
        idle(4);
        chk("queue empty flag", 8'(routeOut[0]), 8'h00);
        rd(ADDR_ACC0, v);
        chk("queue into acc", v, 8'h44);
        $display("done: queue");
        arrayTrue[0][0][0] = 1'b1;
        arraySum[0][0][0] = 1'b1;
        arrayIn[0][0] = 1'b1;
        idle(3);
        chk("array high", 8'(arrayOut[0][0]), 8'h01);
        arrayIn[0][0] = 1'b0;
        idle(3);
        chk("array low", 8'(arrayOut[0][0]), 8'h00);
        arrayReg[0][0] = 1'b1;
        arrayIn[0][0] = 1'b1;
        idle(1);
        chk("array reg early", 8'(arrayOut[0][0]), 8'h00);
        idle(1);
        chk("array reg late", 8'(arrayOut[0][0]), 8'h01);
        $display("done: array");
        wr(ADDR_MODE, 8'h1C);
        wr(ADDR_CTRL, 8'h02);
        wr(ADDR_CFGLO, 8'h03);
        wr(ADDR_CFGHI, 8'h22);
        cIn = 1'b1;
        cfgSel = 3'h2;
        idle(1);
        cfgSel = 3'h0;
        idle(3);
        rd(ADDR_ACC0, v);
        chk("chained add", v, 8'hEA);
        $display("done: datapath");
        wr(ADDR_MASK0, 8'h0F);
        wr(ADDR_CTRL, 8'hC3);
        srst = 1'b1;
        idle(1);
        srst = 1'b0;
        chk("reset control", fabricControl, 8'h00);
        rd(ADDR_MASK0, v);
        chk("reset mask", v, 8'hFF);
        rd(ADDR_STKY, v);
        chk("sticky latched", v, 8'h33);
        rd(ADDR_STKY, v);
        chk("sticky cleared", v, 8'h0F);
        $display("done: reset");
        close_out;
    end
endmodule
bind logic_datapath_cell cell_monitor MON (.ref_clk(ref_clk), .srst(srst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .fabricStatus(fabricStatus), .fabricControl(fabricControl));
